// ===== rtl/oag_addr_gen.sv
// operand address generator: fetches operand bytes, forms effective address
`timescale 1ns/1ps
`default_nettype none
module oag_addr_gen #(
	parameter int ADDR_W = 16
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire oag_pkg::oag_req_t req,
	input  wire logic [15:0]       pc,
	input  wire logic [7:0]        idx_x,
	input  wire logic [7:0]        idx_y,
	output oag_pkg::oag_mem_t      mem,
	input  wire logic              mem_ack,
	input  wire logic [7:0]        mem_rdata,
	output logic                   busy,
	output logic                   done,
	output oag_pkg::oag_res_t      res,
	output logic [1:0]             imask
);
	import oag_pkg::*;

	// elaboration check: the sequencer forms 16-bit addresses only
	if (ADDR_W != 16) begin : g_addr_w_bad
		$error("oag_addr_gen: only a 16-bit address space is served");
	end

	typedef struct packed {
		oag_state_t  state;
		oag_req_t    req;
		logic [15:0] fetch_addr;
		logic [7:0]  b1;
		logic [7:0]  b2;
		logic [7:0]  ptr_hi;
		logic [7:0]  index;
		logic [15:0] mem_addr;
		logic        mem_rd;
		logic        done;
		oag_res_t    res;
	} oag_st_t;

	oag_st_t st_q;
	oag_st_t st_d;

	logic [1:0] nb;
	logic       is_ptr;
	logic       ptr_word;
	logic       indexed;
	logic       short_form;

	// decode of the mode held for the current instruction
	oag_mode_info u_info (
		.mode       (st_q.req.mode),
		.nbytes     (nb),
		.is_ptr     (is_ptr),
		.ptr_word   (ptr_word),
		.indexed    (indexed),
		.short_form (short_form)
	);

	// decode of the incoming request, for length and legality
	logic [1:0] nb_in;
	logic       short_in;
	oag_mode_info u_info_in (
		.mode       (req.mode),
		.nbytes     (nb_in),
		.is_ptr     (),
		.ptr_word   (),
		.indexed    (),
		.short_form (short_in)
	);

	// 8-bit zero extension into the address space
	function automatic logic [15:0] zext8(input logic [7:0] v);
		zext8 = {8'h00, v};
	endfunction : zext8

	// unsigned index plus offset
	function automatic logic [15:0] add_idx(input logic [15:0] base, input logic [7:0] ix);
		add_idx = base + zext8(ix);
	endfunction : add_idx

	wire start_ok = start && (st_q.state == OAG_S_IDLE);
	// rmw on a long form, or immediate, is not served
	wire rmw_bad = req.rmw && !(short_in || req.mode == OAG_M_INH);

	// sequencer
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		case (st_q.state)
			OAG_S_IDLE: begin
				if (start_ok) begin
					st_d.req = req;
					st_d.index = req.use_y ? idx_y : idx_x;
					st_d.fetch_addr = pc + 16'h0001;
					st_d.res.illegal = rmw_bad;
					st_d.res.len = OAG_LEN_BASE + {1'b0, nb_in};
					st_d.res.is_imm = (req.mode == OAG_M_IMM);
					st_d.res.ea = 16'h0000;
					st_d.res.imm = 8'h00;
					if (rmw_bad || nb_in == 2'd0) begin
						st_d.state = OAG_S_DONE;
					end else begin
						st_d.mem_addr = pc + 16'h0001;
						st_d.mem_rd = 1'b1;
						st_d.state = OAG_S_FB1;
					end
				end
			end
			OAG_S_FB1: begin
				if (mem_ack) begin
					st_d.b1 = mem_rdata;
					if (nb == 2'd2) begin
						st_d.mem_addr = st_q.fetch_addr + 16'h0001;
						st_d.state = OAG_S_FB2;
					end else if (is_ptr) begin
						st_d.mem_addr = zext8(mem_rdata); // pointer in zero page
						st_d.state = OAG_S_PTR1;
					end else begin
						st_d.mem_rd = 1'b0;
						st_d.state = OAG_S_DONE;
					end
				end
			end
			OAG_S_FB2: begin
				if (mem_ack) begin
					st_d.b2 = mem_rdata;
					st_d.mem_rd = 1'b0;
					st_d.state = OAG_S_DONE;
				end
			end
			OAG_S_PTR1: begin
				if (mem_ack) begin
					st_d.ptr_hi = mem_rdata;
					if (ptr_word) begin
						st_d.mem_addr = zext8(st_q.b1 + 8'h01);
						st_d.state = OAG_S_PTR2;
					end else begin
						st_d.mem_rd = 1'b0;
						st_d.state = OAG_S_DONE;
					end
				end
			end
			OAG_S_PTR2: begin
				if (mem_ack) begin
					st_d.b2 = mem_rdata;
					st_d.mem_rd = 1'b0;
					st_d.state = OAG_S_DONE;
				end
			end
			OAG_S_DONE: begin
				st_d.done = 1'b1;
				st_d.state = OAG_S_IDLE;
				case (st_q.req.mode)
					OAG_M_IMM:   st_d.res.imm = st_q.b1;
					OAG_M_DIR_S: st_d.res.ea = zext8(st_q.b1);
					OAG_M_DIR_L: st_d.res.ea = {st_q.b1, st_q.b2};
					OAG_M_IDX_0: st_d.res.ea = zext8(st_q.index);
					OAG_M_IDX_S: st_d.res.ea = add_idx(zext8(st_q.b1), st_q.index);
					OAG_M_IDX_L: st_d.res.ea = add_idx({st_q.b1, st_q.b2}, st_q.index);
					OAG_M_IND_S: st_d.res.ea = zext8(st_q.ptr_hi);
					OAG_M_IND_L: st_d.res.ea = {st_q.ptr_hi, st_q.b2};
					OAG_M_INX_S: st_d.res.ea = add_idx(zext8(st_q.ptr_hi), st_q.index);
					OAG_M_INX_L: st_d.res.ea = add_idx({st_q.ptr_hi, st_q.b2}, st_q.index);
					default:     st_d.res.ea = 16'h0000;
				endcase
			end
			default: st_d.state = OAG_S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// interrupt mask level, driven by inherent ops when taken
	oag_imask u_imask (
		.ref_clk (ref_clk),
		.rst     (rst),
		.set_all (start_ok && req.mode == OAG_M_INH && req.op == OAG_OP_MASK_ALL_INTERRUPTS),
		.clr_all (start_ok && req.mode == OAG_M_INH && req.op == OAG_OP_UNMASK_INTERRUPTS),
		.level   (imask)
	);

	assign mem.rd   = st_q.mem_rd;
	assign mem.addr = st_q.mem_addr;
	assign busy     = st_q.state != OAG_S_IDLE;
	assign done     = st_q.done;
	assign res      = st_q.res;

	// checks
	property p_short_zpage;
		@(posedge ref_clk) disable iff (rst)
		done && (st_q.req.mode inside {OAG_M_DIR_S, OAG_M_IDX_0, OAG_M_IND_S}) |-> res.ea <= OAG_ZPAGE_MAX;
	endproperty
	a_short_zpage: assert property (p_short_zpage) else $error("short form left zero page");

	property p_idx_s_max;
		@(posedge ref_clk) disable iff (rst)
		done && (st_q.req.mode inside {OAG_M_IDX_S, OAG_M_INX_S}) |-> res.ea <= 16'h01FE;
	endproperty
	a_idx_s_max: assert property (p_idx_s_max) else $error("short indexed beyond 1FE");

	property p_inh_len;
		@(posedge ref_clk) disable iff (rst)
		start_ok && req.mode == OAG_M_INH && !req.rmw |=> ##1 done && res.len == 3'h1;
	endproperty
	a_inh_len: assert property (p_inh_len) else $error("inherent not one byte");

	property p_rmw_long;
		@(posedge ref_clk) disable iff (rst)
		start_ok && req.rmw && req.mode == OAG_M_DIR_L |=> ##1 done && res.illegal;
	endproperty
	a_rmw_long: assert property (p_rmw_long) else $error("long rmw accepted");

	property p_mask;
		@(posedge ref_clk) disable iff (rst)
		start_ok && req.mode == OAG_M_INH && req.op == OAG_OP_MASK_ALL_INTERRUPTS |=> imask == 2'h3;
	endproperty
	a_mask: assert property (p_mask) else $error("mask level not 3");

	property p_unmask;
		@(posedge ref_clk) disable iff (rst)
		start_ok && req.mode == OAG_M_INH && req.op == OAG_OP_UNMASK_INTERRUPTS |=> imask == 2'h0;
	endproperty
	a_unmask: assert property (p_unmask) else $error("mask level not 0");

	property p_first_fetch;
		@(posedge ref_clk) disable iff (rst)
		start_ok && req.mode == OAG_M_DIR_S |=> mem.rd && mem.addr == $past(pc) + 16'h0001;
	endproperty
	a_first_fetch: assert property (p_first_fetch) else $error("operand fetch not at pc+1");

	property p_ptr_read;
		@(posedge ref_clk) disable iff (rst)
		st_q.state == OAG_S_FB1 && mem_ack && is_ptr |=> mem.rd && mem.addr == {8'h00, $past(mem_rdata)};
	endproperty
	a_ptr_read: assert property (p_ptr_read) else $error("pointer not read at zero page");

	property p_idx0;
		@(posedge ref_clk) disable iff (rst)
		done && st_q.req.mode == OAG_M_IDX_0 |-> res.ea == {8'h00, st_q.index};
	endproperty
	a_idx0: assert property (p_idx0) else $error("no-offset indexed address wrong");

	property p_long_second;
		@(posedge ref_clk) disable iff (rst)
		st_q.state == OAG_S_FB1 && mem_ack && nb == 2'd2 |=> mem.rd && mem.addr == st_q.fetch_addr + 16'h0001;
	endproperty
	a_long_second: assert property (p_long_second) else $error("second operand byte not at pc+2");

	property p_ptr_second;
		@(posedge ref_clk) disable iff (rst)
		st_q.state == OAG_S_PTR1 && mem_ack && ptr_word |=> mem.rd && mem.addr[15:8] == 8'h00 &&
			mem.addr[7:0] == st_q.b1 + 8'h01;
	endproperty
	a_ptr_second: assert property (p_ptr_second) else $error("pointer low byte not read next in zero page");

	property p_illegal_no_fetch;
		@(posedge ref_clk) disable iff (rst)
		start_ok && rmw_bad |=> !mem.rd && st_q.state == OAG_S_DONE;
	endproperty
	a_illegal_no_fetch: assert property (p_illegal_no_fetch) else $error("refused rmw started a fetch");

	property p_inh_no_fetch;
		@(posedge ref_clk) disable iff (rst)
		start_ok && req.mode == OAG_M_INH |=> !mem.rd && busy;
	endproperty
	a_inh_no_fetch: assert property (p_inh_no_fetch) else $error("inherent op fetched a byte");

	property p_imm_fetch;
		@(posedge ref_clk) disable iff (rst)
		start_ok && req.mode == OAG_M_IMM && !req.rmw |=> mem.rd && mem.addr == $past(pc) + 16'h0001;
	endproperty
	a_imm_fetch: assert property (p_imm_fetch) else $error("immediate operand not fetched at pc+1");

	// short forms: plain ones stay in zero page, indexed ones reach 1FE at most
	property p_short_span;
		@(posedge ref_clk) disable iff (rst)
		done && short_form |-> (indexed ? (res.ea <= 16'h01FE) : (res.ea <= OAG_ZPAGE_MAX));
	endproperty
	a_short_span: assert property (p_short_span) else $error("short form address out of span");

	c_done_imm: cover property (@(posedge ref_clk) done && st_q.req.mode == OAG_M_IMM);
	c_done_inxl: cover property (@(posedge ref_clk) done && st_q.req.mode == OAG_M_INX_L);
	c_done_idxl: cover property (@(posedge ref_clk) done && st_q.req.mode == OAG_M_IDX_L);
	c_done_illegal: cover property (@(posedge ref_clk) done && res.illegal);

endmodule : oag_addr_gen
`default_nettype wire

// ===== rtl/oag_imask.sv
// interrupt mask level register
`timescale 1ns/1ps
`default_nettype none
module oag_imask (
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire logic            set_all,
	input  wire logic            clr_all,
	output logic [1:0]           level
);
	import oag_pkg::*;

	typedef struct packed {
		logic [1:0] level;
	} oag_imask_st_t;

	oag_imask_st_t st_q;
	oag_imask_st_t st_d;

	// mask/unmask from decoded inherent ops
	always_comb begin
		st_d = st_q;
		if (set_all) begin
			st_d.level = OAG_IMASK_ALL;
		end else if (clr_all) begin
			st_d.level = OAG_IMASK_NONE;
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= '{level: OAG_IMASK_RST};
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.level;

endmodule : oag_imask
`default_nettype wire

// ===== rtl/oag_mode_info.sv
// mode decode: operand byte count, pointer use and size
`timescale 1ns/1ps
`default_nettype none
module oag_mode_info (
	input  wire oag_pkg::oag_mode_t mode,
	output logic [1:0]              nbytes,
	output logic                    is_ptr,
	output logic                    ptr_word,
	output logic                    indexed,
	output logic                    short_form
);
	import oag_pkg::*;

	// per-mode properties
	always_comb begin
		nbytes     = 2'd0;
		is_ptr     = 1'b0;
		ptr_word   = 1'b0;
		indexed    = 1'b0;
		short_form = 1'b0;
		case (mode)
			OAG_M_IMM:   begin nbytes = 2'd1; end
			OAG_M_DIR_S: begin nbytes = 2'd1; short_form = 1'b1; end
			OAG_M_DIR_L: begin nbytes = 2'd2; end
			OAG_M_IDX_0: begin indexed = 1'b1; short_form = 1'b1; end
			OAG_M_IDX_S: begin nbytes = 2'd1; indexed = 1'b1; short_form = 1'b1; end
			OAG_M_IDX_L: begin nbytes = 2'd2; indexed = 1'b1; end
			OAG_M_IND_S: begin nbytes = 2'd1; is_ptr = 1'b1; short_form = 1'b1; end
			OAG_M_IND_L: begin nbytes = 2'd1; is_ptr = 1'b1; ptr_word = 1'b1; end
			OAG_M_INX_S: begin nbytes = 2'd1; is_ptr = 1'b1; indexed = 1'b1; short_form = 1'b1; end
			OAG_M_INX_L: begin nbytes = 2'd1; is_ptr = 1'b1; ptr_word = 1'b1; indexed = 1'b1; end
			default:     begin nbytes = 2'd0; end
		endcase
	end

endmodule : oag_mode_info
`default_nettype wire

// ===== rtl/oag_pkg.sv
// package: addressing modes, operation classes, bus carriers and constants
package oag_pkg;

	// addressing modes, as presented by the opcode decoder
	typedef enum logic [3:0] {
		OAG_M_INH     = 4'h0,
		OAG_M_IMM     = 4'h1,
		OAG_M_DIR_S   = 4'h2,
		OAG_M_DIR_L   = 4'h3,
		OAG_M_IDX_0   = 4'h4,
		OAG_M_IDX_S   = 4'h5,
		OAG_M_IDX_L   = 4'h6,
		OAG_M_IND_S   = 4'h7,
		OAG_M_IND_L   = 4'h8,
		OAG_M_INX_S   = 4'h9,
		OAG_M_INX_L   = 4'hA
	} oag_mode_t;

	// inherent operation classes that matter to this block
	typedef enum logic [1:0] {
		OAG_OP_OTHER                  = 2'h0,
		OAG_OP_MASK_ALL_INTERRUPTS    = 2'h1,
		OAG_OP_UNMASK_INTERRUPTS      = 2'h2
	} oag_op_t;

	// sequencer states
	typedef enum logic [2:0] {
		OAG_S_IDLE  = 3'b000,
		OAG_S_FB1   = 3'b001,
		OAG_S_FB2   = 3'b010,
		OAG_S_PTR1  = 3'b011,
		OAG_S_PTR2  = 3'b100,
		OAG_S_DONE  = 3'b101
	} oag_state_t;

	// decoded instruction request
	typedef struct packed {
		oag_mode_t mode;
		oag_op_t   op;
		logic      use_y;
		logic      rmw;
	} oag_req_t;

	// memory read request
	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} oag_mem_t;

	// result handed to the execution stage
	typedef struct packed {
		logic [15:0] ea;
		logic [7:0]  imm;
		logic        is_imm;
		logic        illegal;
		logic [2:0]  len;
	} oag_res_t;

	localparam logic [15:0] OAG_ZPAGE_MAX  = 16'h00FF;
	localparam logic [1:0]  OAG_IMASK_ALL  = 2'h3;
	localparam logic [1:0]  OAG_IMASK_NONE = 2'h0;
	localparam logic [1:0]  OAG_IMASK_RST  = 2'h3;
	localparam logic [2:0]  OAG_LEN_BASE   = 3'h1;

endpackage : oag_pkg

// ===== tb/oag_addr_gen_test.sv
// testbench: random and corner instructions against computed addresses
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module oag_addr_gen_test;
	import oag_pkg::*;
	logic        ref_clk, rst, start, mem_ack, busy, done, saw_rd;
	logic [15:0] pc;
	logic [7:0]  idx_x, idx_y, mem_rdata;
	logic [1:0]  exp_mask;
	oag_req_t    req, r;
	oag_mem_t    mem;
	oag_res_t    res;
	logic [1:0]  imask;
	int          fail_count, n_compared;
	oag_addr_gen u_dut (.ref_clk(ref_clk), .rst(rst), .start(start), .req(req), .pc(pc), .idx_x(idx_x),
		.idx_y(idx_y), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
		.res(res), .imask(imask));
	oag_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// note any read issued
	always @(posedge ref_clk) if (mem.rd === 1'b1) saw_rd = 1'b1;
	// memory content, the same fixed function of the address as the partner model
	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : mem_byte
	// expected result of one instruction
	function automatic oag_res_t exp_res(input oag_req_t q, input logic [15:0] p, input logic [7:0] x);
		logic [7:0]  b1, b2, pl;
		logic [15:0] pw;
		oag_res_t    e;
		b1 = mem_byte(p + 16'h0001);
		b2 = mem_byte(p + 16'h0002);
		pl = mem_byte({8'h00, b1});
		pw = {pl, mem_byte({8'h00, b1 + 8'h01})};
		e = '0;
		e.len = 3'h2;
		case (q.mode)
			OAG_M_INH: e.len = OAG_LEN_BASE;
			OAG_M_IMM: begin e.imm = b1; e.is_imm = 1'b1; end
			OAG_M_DIR_S: e.ea = {8'h00, b1};
			OAG_M_DIR_L: begin e.ea = {b1, b2}; e.len = 3'h3; end
			OAG_M_IDX_0: begin e.ea = {8'h00, x}; e.len = OAG_LEN_BASE; end
			OAG_M_IDX_S: e.ea = {8'h00, b1} + {8'h00, x};
			OAG_M_IDX_L: begin e.ea = {b1, b2} + {8'h00, x}; e.len = 3'h3; end
			OAG_M_IND_S: e.ea = {8'h00, pl};
			OAG_M_IND_L: e.ea = pw;
			OAG_M_INX_S: e.ea = {8'h00, pl} + {8'h00, x};
			default: e.ea = pw + {8'h00, x};
		endcase
		e.illegal = q.rmw && (q.mode inside {OAG_M_IMM, OAG_M_DIR_L, OAG_M_IDX_L, OAG_M_IND_L, OAG_M_INX_L});
		return e;
	endfunction : exp_res
	// end of run
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// issue one instruction, wait for done, compare
	task automatic run(input oag_req_t q, input logic [15:0] p, input logic [7:0] x, input logic [7:0] y);
		oag_res_t e;
		int       n;
		e = exp_res(q, p, q.use_y ? y : x);
		if (q.mode == OAG_M_INH && q.op == OAG_OP_MASK_ALL_INTERRUPTS) exp_mask = OAG_IMASK_ALL;
		if (q.mode == OAG_M_INH && q.op == OAG_OP_UNMASK_INTERRUPTS) exp_mask = OAG_IMASK_NONE;
		req = q;
		pc = p;
		idx_x = x;
		idx_y = y;
		start = 1'b1;
		saw_rd = 1'b0;
		@(posedge ref_clk);
		#1 start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n == 100) begin
			fail_count++;
			test_done();
		end
		if (e.illegal) begin
			`CHK("illegal", 1'b1, res.illegal)
			`CHK("no_fetch", 1'b0, saw_rd)
		end else begin
			`CHK("ea", e.ea, res.ea)
			`CHK("is_imm", e.is_imm, res.is_imm)
			if (e.is_imm) `CHK("imm", e.imm, res.imm)
			`CHK("len", e.len, res.len)
			`CHK("legal", 1'b0, res.illegal)
			// no operand bytes: done stands one edge after the start edge
			if (q.mode inside {OAG_M_INH, OAG_M_IDX_0}) `CHK("latency", 1, n)
		end
		`CHK("imask", exp_mask, imask)
		@(posedge ref_clk);
		#1 `CHK("done_pulse", 1'b0, done)
	endtask : run
	// main sequence
	initial begin
		fail_count = 0;
		n_compared = 0;
		rst = 1'b1;
		start = 1'b0;
		req = '0;
		pc = 16'h0000;
		idx_x = 8'h00;
		idx_y = 8'h00;
		exp_mask = OAG_IMASK_RST;
		void'($urandom(94513));
		repeat (3) @(posedge ref_clk);
		#1 rst = 1'b0;
		`CHK("imask_rst", OAG_IMASK_RST, imask)
		r = '0;
		r.op = OAG_OP_UNMASK_INTERRUPTS;
		run(r, 16'h1000, 8'h00, 8'h00);
		r.op = OAG_OP_MASK_ALL_INTERRUPTS;
		run(r, 16'h1001, 8'h00, 8'h00);
		// every mode at carry and wrap corners, both index registers
		for (int c = 0; c < 2; c++) begin
			for (int m = 0; m < 11; m++) begin
				r = '0;
				r.mode = oag_mode_t'(m);
				r.use_y = c[0];
				run(r, c[0] ? 16'h00FE : 16'h00A4, c[0] ? 8'h00 : 8'hFF, c[0] ? 8'hFF : 8'h00);
			end
		end
		// memory-operating forms over all modes but no-offset
		for (int m = 0; m < 11; m++) begin
			r = '0;
			r.mode = oag_mode_t'(m);
			r.rmw = (m != 4);
			run(r, 16'($urandom), 8'($urandom), 8'($urandom));
		end
		repeat (150) begin
			r.mode = oag_mode_t'($urandom_range(10, 0));
			r.op = (r.mode == OAG_M_INH) ? oag_op_t'($urandom_range(2, 0)) : OAG_OP_OTHER;
			r.use_y = 1'($urandom);
			r.rmw = (r.mode != OAG_M_IDX_0) && ($urandom_range(3, 0) == 0);
			run(r, 16'($urandom), 8'($urandom), 8'($urandom));
		end
		// reset in mid-fetch
		req.mode = OAG_M_INX_L;
		req.rmw = 1'b0;
		start = 1'b1;
		@(posedge ref_clk);
		#1 start = 1'b0;
		rst = 1'b1;
		#1 `CHK("rst_done", 1'b0, done)
		`CHK("rst_imask", OAG_IMASK_RST, imask)
		// release again and check a clean instruction right after it
		repeat (2) @(posedge ref_clk);
		#1 rst = 1'b0;
		exp_mask = OAG_IMASK_RST;
		r = '0;
		r.mode = OAG_M_DIR_S;
		run(r, 16'h0040, 8'h00, 8'h00);
		test_done();
	end
endmodule : oag_addr_gen_test
`undef CHK
`default_nettype wire

// ===== tb/oag_mem_model.sv
// partner model: byte memory answering reads after random stalls
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire oag_pkg::oag_mem_t mem,
	output logic                   mem_ack,
	output logic [7:0]             mem_rdata
);
	import oag_pkg::*;
	// content is a fixed function of the address
	function automatic logic [7:0] byte_at(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : byte_at
	// one-cycle answer, sometimes late; data toggles when not answering
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mem_ack   <= 1'b0;
			mem_rdata <= 8'h00;
		end else if (mem.rd && !mem_ack && ($urandom_range(1, 0) == 0)) begin
			mem_ack   <= 1'b1;
			mem_rdata <= byte_at(mem.addr);
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : oag_mem_model
`default_nettype wire
